// *** rtl/imsar_pkg.sv ***
package imsar_pkg;
    localparam int          PAY_OCT    = 48;          // octets in one segment payload
    localparam int          SU_OCT     = 44;          // octets in one segmentation unit
    localparam int          HDR_OCT    = 2;           // unit header octets ahead of the su
    localparam int          HOLD_OCT   = 4;           // octets held back per reassembly
    localparam int          ADDR_POS   = 4;           // destination address offset in su
    localparam int          ADDR_OCT   = 8;           // destination address octets
    localparam int          BETAG_POS  = 1;           // tag octet in common header/trailer
    localparam int          BAS_POS    = 2;           // length field in common header
    localparam int          CRCP_POS   = 21;          // su octet holding the crc32 flag
    localparam int          CRCP_BIT   = 3;           // bit of the crc32 flag
    localparam int          WORD_BITS  = 32;
    localparam int          TRL_BITS   = 22;          // carried octets plus length field
    localparam logic [3:0]  LAST_WORD  = 4'hb;        // 12 words per segment payload
    localparam logic [1:0]  ST_COM     = 2'h0;
    localparam logic [1:0]  ST_EOM     = 2'h1;
    localparam logic [1:0]  ST_BOM     = 2'h2;
    localparam logic [1:0]  ST_SSM     = 2'h3;
    localparam logic [9:0]  MID_NONE   = 10'h000;
    localparam logic [15:0] SU_OCT16   = 16'h002c;
    localparam logic [15:0] WD_OCT16   = 16'h0004;
    localparam logic [15:0] CPDU_OCT16 = 16'h0008;    // common header plus trailer
    localparam logic [5:0]  SU_OCT6    = 6'h2c;
    localparam logic [5:0]  SSM_MIN6   = 6'h1c;       // 28 octets
    localparam logic [5:0]  EOM_MIN6   = 6'h04;
    localparam logic [5:0]  CAT_LO6    = 6'h08;       // skip held word and common header
    localparam logic [9:0]  CRC10_POLY = 10'h233;
    localparam logic [9:0]  CRC10_INIT = 10'h000;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT = 32'hffffffff;
    localparam logic [31:0] CRC32_RES  = 32'hc704dd7b;
    localparam logic [19:0] VCI_DEFAULT = 20'hfffff;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } imsar_tx_t;

    function automatic logic [9:0] crc10(input logic [9:0] c, input logic [31:0] d, input int n);
        logic [9:0] r;
        r = c;
        for (int i = 0; i < WORD_BITS; i++) begin
            if (i < n) r = {r[8:0], 1'b0} ^ ((r[9] ^ d[31-i]) ? CRC10_POLY : 10'h000);
        end
        return r;
    endfunction

    function automatic logic [31:0] crc32(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[7-i]) ? CRC32_POLY : 32'h00000000);
        end
        return r;
    endfunction
endpackage

// *** rtl/imsar_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - multi-unit message starts with begin unit
// - begin unit carries caller's free identifier
// - sequence number increments by one per unit
// - begin unit filled with header then data
// - middle units continue, final unit ends
// - all units repeat the begin identifier
// - single unit message uses identifier zero
// - begin and middle lengths are 44
// - end length is remaining octets, 4..44
// - single length is whole message, 28..44
// - payload crc covers header, unit, trailer
// - drop units failing crc on our channels
// - copy begin unit only if addressed here
// - record sequence and identifier on begin
// - copy matching units with expected sequence
// - matching end unit completes the message
// - discard message on length mismatch
// - tag sent twice, incremented; mismatch discards
// - check optional crc32 when flagged present
// - free identifier once message completes
// - per-identifier timer discards stalled message
// - several reassemblies; default channel always accepted
// - header type,sequence,identifier; trailer length,crc
// - 24 octet header, 4 common, 20 more
module imsar_top #(
    parameter int NSLOT    = 4,    // concurrent reassemblies, at least 2
    parameter int TMR_W    = 24,   // timeout counter width
    parameter bit CRC32_EN = 1'b1  // crc32 checking supported
) (
    input  wire logic               MCLK_I,            // clock
    input  wire logic               RESETN_I,          // async reset, low
    input  wire logic               CE_I,              // clock enable
    input  wire logic               TX_START_I,        // begin a message
    input  wire logic [15:0]        TX_LEN_I,          // message octets
    input  wire logic [9:0]         TX_MID_I,          // identifier to use
    output logic                    TX_BUSY_O,         // sending
    input  wire logic [31:0]        TX_DATA_I,         // message word
    input  wire logic               TX_VALID_I,        // message word valid
    output logic                    TX_READY_O,        // message word taken
    output logic [31:0]             TX_DMPDU_O,        // payload word out
    output logic                    TX_DMPDU_VALID_O,  // payload word valid
    output logic                    TX_DMPDU_FIRST_O,  // first payload word
    input  wire logic               TX_DMPDU_READY_I,  // payload word taken
    input  wire logic [31:0]        RX_DATA_I,         // received payload word
    input  wire logic               RX_VALID_I,        // received word valid
    input  wire logic               RX_FIRST_I,        // first word of payload
    input  wire logic [19:0]        RX_VCI_I,          // channel of payload
    input  wire logic [19:0]        RX_PROG_VCI_I,     // programmed channel
    input  wire logic [63:0]        RX_ADDR_I,         // own address
    input  wire logic [TMR_W-1:0]   RX_TIMEOUT_I,      // reassembly timeout cycles
    output logic [351:0]            RX_SU_O,           // copied unit
    output logic                    RX_SU_VALID_O,     // unit copied
    output logic                    RX_SU_FIRST_O,     // unit starts a message
    output logic [5:0]              RX_SU_LEN_O,       // unit octets
    output logic [$clog2(NSLOT)-1:0] RX_SU_SLOT_O,     // reassembly slot
    output logic                    RX_END_O,          // message complete
    output logic                    RX_GOOD_O,         // message valid
    output logic [$clog2(NSLOT)-1:0] RX_END_SLOT_O,    // slot completed
    output logic [NSLOT-1:0]        RX_EXPIRE_O        // slot timed out
);
    localparam int SW = $clog2(NSLOT);

    imsar_pkg::imsar_tx_t tx_st_q;
    logic [15:0] rem_q;
    logic [9:0]  mid_q;
    logic [3:0]  sn_q;
    logic [3:0]  wcnt_q;
    logic        first_q;
    logic        dfirst_q;
    logic [15:0] carry_q;
    logic [9:0]  crc_q;
    logic [7:0]  betag_q;
    logic [1:0]  ust_q;
    logic [5:0]  uplen_q;
    logic        txl_q;
    logic [15:0] cur_hdr_q;
    logic [15:0] prev_hdr_q;
    logic        need_d;
    logic        step;
    logic [1:0]  ust_c;
    logic [5:0]  uplen_c;
    logic [31:0] dmod;
    logic [31:0] word_c;

    assign TX_BUSY_O  = (tx_st_q == imsar_pkg::TX_SEND);
    assign need_d     = (wcnt_q != imsar_pkg::LAST_WORD) && (rem_q != 16'h0000);
    assign step       = TX_BUSY_O && (!TX_DMPDU_VALID_O || TX_DMPDU_READY_I) && (!need_d || TX_VALID_I);
    assign TX_READY_O = TX_BUSY_O && (!TX_DMPDU_VALID_O || TX_DMPDU_READY_I) && need_d;

    always_comb begin
        dmod = TX_DATA_I;
        if (dfirst_q || rem_q == imsar_pkg::WD_OCT16) dmod[23:16] = betag_q;
        if (!need_d) dmod = 32'h00000000;
        if (rem_q <= imsar_pkg::SU_OCT16) begin
            ust_c   = first_q ? imsar_pkg::ST_SSM : imsar_pkg::ST_EOM;
            uplen_c = rem_q[5:0];
        end else begin
            ust_c   = first_q ? imsar_pkg::ST_BOM : imsar_pkg::ST_COM;
            uplen_c = imsar_pkg::SU_OCT6;
        end
        if (wcnt_q == 4'h0) begin
            word_c = {ust_c, sn_q, (ust_c == imsar_pkg::ST_SSM) ? imsar_pkg::MID_NONE : mid_q, dmod[31:16]};
        end else if (wcnt_q == imsar_pkg::LAST_WORD) begin
            word_c = {carry_q, uplen_q, imsar_pkg::crc10(crc_q, {carry_q, uplen_q, 10'h000}, imsar_pkg::TRL_BITS)};
        end else begin
            word_c = {carry_q, dmod[31:16]};
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_st_q  <= imsar_pkg::TX_IDLE;
            rem_q    <= 16'h0000;
            mid_q    <= 10'h000;
            sn_q     <= 4'h0;
            wcnt_q   <= 4'h0;
            first_q  <= 1'b0;
            dfirst_q <= 1'b0;
            carry_q  <= 16'h0000;
            crc_q    <= imsar_pkg::CRC10_INIT;
            betag_q  <= 8'h00;
            ust_q    <= imsar_pkg::ST_COM;
            uplen_q  <= 6'h00;
        end else if (CE_I) begin
            unique case (tx_st_q)
                imsar_pkg::TX_IDLE: if (TX_START_I) begin
                    rem_q    <= TX_LEN_I;
                    mid_q    <= TX_MID_I;
                    first_q  <= 1'b1;
                    dfirst_q <= 1'b1;
                    wcnt_q   <= 4'h0;
                    tx_st_q  <= imsar_pkg::TX_SEND;
                end
                imsar_pkg::TX_SEND: if (step) begin
                    if (need_d) rem_q <= rem_q - imsar_pkg::WD_OCT16;
                    dfirst_q <= 1'b0;
                    carry_q  <= dmod[15:0];
                    if (wcnt_q == 4'h0) begin
                        ust_q   <= ust_c;
                        uplen_q <= uplen_c;
                        crc_q   <= imsar_pkg::crc10(imsar_pkg::CRC10_INIT, word_c, imsar_pkg::WORD_BITS);
                    end else begin
                        crc_q   <= imsar_pkg::crc10(crc_q, word_c, imsar_pkg::WORD_BITS);
                    end
                    if (wcnt_q == imsar_pkg::LAST_WORD) begin
                        wcnt_q  <= 4'h0;
                        sn_q    <= sn_q + 4'h1;
                        first_q <= 1'b0;
                        if (rem_q == 16'h0000) begin
                            tx_st_q <= imsar_pkg::TX_IDLE;
                            betag_q <= betag_q + 8'h01;
                        end
                    end else begin
                        wcnt_q <= wcnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // output stage with the header history used by the checks
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            TX_DMPDU_O       <= 32'h00000000;
            TX_DMPDU_VALID_O <= 1'b0;
            TX_DMPDU_FIRST_O <= 1'b0;
            txl_q            <= 1'b0;
            cur_hdr_q        <= 16'h0000;
            prev_hdr_q       <= 16'h0000;
        end else if (CE_I) begin
            if (step) begin
                TX_DMPDU_O       <= word_c;
                TX_DMPDU_VALID_O <= 1'b1;
                TX_DMPDU_FIRST_O <= (wcnt_q == 4'h0);
                txl_q            <= (wcnt_q == imsar_pkg::LAST_WORD);
                if (wcnt_q == 4'h0) begin
                    cur_hdr_q  <= word_c[31:16];
                    prev_hdr_q <= cur_hdr_q;
                end
            end else if (TX_DMPDU_READY_I) begin
                TX_DMPDU_VALID_O <= 1'b0;
            end
        end
    end

    // receive: collect one segment payload
    logic [3:0]  rwc_q;
    logic [7:0]  pl_q [imsar_pkg::PAY_OCT];
    logic [9:0]  rcrc_q;
    logic [19:0] rvci_q;
    logic        rdone_q;
    logic        rok_q;
    logic [3:0]  widx;
    logic [9:0]  rcrc_c;

    assign widx   = RX_FIRST_I ? 4'h0 : rwc_q;
    assign rcrc_c = imsar_pkg::crc10(RX_FIRST_I ? imsar_pkg::CRC10_INIT : rcrc_q, RX_DATA_I, imsar_pkg::WORD_BITS);

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rwc_q   <= 4'h0;
            rcrc_q  <= imsar_pkg::CRC10_INIT;
            rvci_q  <= 20'h00000;
            rdone_q <= 1'b0;
            rok_q   <= 1'b0;
            for (int i = 0; i < imsar_pkg::PAY_OCT; i++) pl_q[i] <= 8'h00;
        end else if (CE_I) begin
            rdone_q <= 1'b0;
            if (RX_VALID_I && (RX_FIRST_I || rwc_q != 4'h0)) begin
                for (int i = 0; i < imsar_pkg::PAY_OCT; i++) begin
                    if (4'(i / 4) == widx) pl_q[i] <= RX_DATA_I[31-8*(i%4) -: 8];
                end
                rcrc_q <= rcrc_c;
                if (RX_FIRST_I) rvci_q <= RX_VCI_I;
                rwc_q <= (widx == imsar_pkg::LAST_WORD) ? 4'h0 : widx + 4'h1;
                if (widx == imsar_pkg::LAST_WORD) begin
                    rdone_q <= 1'b1;
                    rok_q   <= (rcrc_c == 10'h000);
                end
            end
        end
    end

    // reassembly slots
    logic [NSLOT-1:0] act_q;
    logic [NSLOT-1:0] crcp_q;
    logic [19:0]      svci_q [NSLOT];
    logic [9:0]       smid_q [NSLOT];
    logic [3:0]       ssn_q  [NSLOT];
    logic [TMR_W-1:0] tmr_q  [NSLOT];
    logic [15:0]      cnt_q  [NSLOT];
    logic [15:0]      bas_q  [NSLOT];
    logic [7:0]       tag_q  [NSLOT];
    logic [31:0]      c32_q  [NSLOT];
    logic [31:0]      hold_q [NSLOT];
    logic [1:0]  st;
    logic [3:0]  sn;
    logic [9:0]  mid;
    logic [5:0]  plen;
    logic        hit, fr, addr_ok, plen_ok, ok, start, single, cont, fin, good, crcp;
    logic [SW-1:0] hs, fs, sel;
    logic [7:0]  cat [imsar_pkg::PAY_OCT];
    logic [5:0]  lo, hi, ulen;
    logic [31:0] c, nhold;
    logic [15:0] cnt_n, bas, body;
    logic [7:0]  tag;
    logic [NSLOT-1:0] exp_c;

    always_comb begin
        st      = pl_q[0][7:6];
        sn      = pl_q[0][5:2];
        mid     = {pl_q[0][1:0], pl_q[1]};
        plen    = pl_q[imsar_pkg::PAY_OCT-2][7:2];
        plen_ok = (plen != 6'h00) && (plen <= imsar_pkg::SU_OCT6) && (plen[1:0] == 2'h0);
        hit = 1'b0;
        fr  = 1'b0;
        hs  = '0;
        fs  = '0;
        for (int i = 0; i < NSLOT; i++) begin
            if (act_q[i] && svci_q[i] == rvci_q && smid_q[i] == mid && !hit) begin
                hit = 1'b1;
                hs  = SW'(i);
            end
            if (!act_q[i] && !fr) begin
                fr = 1'b1;
                fs = SW'(i);
            end
        end
        addr_ok = 1'b1;
        for (int k = 0; k < imsar_pkg::ADDR_OCT; k++) begin
            if (pl_q[imsar_pkg::HDR_OCT+imsar_pkg::ADDR_POS+k] != RX_ADDR_I[63-8*k -: 8]) addr_ok = 1'b0;
        end
        ok     = rdone_q && rok_q && (rvci_q == RX_PROG_VCI_I || rvci_q == imsar_pkg::VCI_DEFAULT);
        start  = ok && st == imsar_pkg::ST_BOM && addr_ok && fr;
        single = ok && st == imsar_pkg::ST_SSM && addr_ok && plen_ok;
        cont   = ok && (st == imsar_pkg::ST_COM || st == imsar_pkg::ST_EOM) && hit && plen_ok
                 && sn == ssn_q[hs] + 4'h1;
        fin    = single || (cont && st == imsar_pkg::ST_EOM);
        sel    = start ? fs : hs;
        for (int k = 0; k < imsar_pkg::HOLD_OCT; k++) cat[k] = hold_q[sel][31-8*k -: 8];
        for (int k = 0; k < imsar_pkg::SU_OCT; k++) cat[imsar_pkg::HOLD_OCT+k] = pl_q[imsar_pkg::HDR_OCT+k];
        ulen = start ? imsar_pkg::SU_OCT6 : plen;
        hi   = (start || !plen_ok) ? imsar_pkg::SU_OCT6 : plen;
        lo   = (start || single) ? imsar_pkg::CAT_LO6 : 6'h00;
        // crc32 runs one word behind so the trailer is never folded in
        c = (start || single) ? imsar_pkg::CRC32_INIT : c32_q[sel];
        for (int i = 0; i < imsar_pkg::PAY_OCT; i++) begin
            if (6'(i) >= lo && 6'(i) < hi) c = imsar_pkg::crc32(c, cat[i]);
        end
        for (int k = 0; k < imsar_pkg::HOLD_OCT; k++) nhold[31-8*k -: 8] = cat[6'(hi + 6'(k))];
        cnt_n = ((start || single) ? 16'h0000 : cnt_q[sel]) + {10'h000, ulen};
        tag   = (start || single) ? pl_q[imsar_pkg::HDR_OCT+imsar_pkg::BETAG_POS] : tag_q[sel];
        bas   = (start || single) ? {pl_q[imsar_pkg::HDR_OCT+imsar_pkg::BAS_POS],
                                     pl_q[imsar_pkg::HDR_OCT+imsar_pkg::BAS_POS+1]} : bas_q[sel];
        crcp  = (start || single) ? pl_q[imsar_pkg::HDR_OCT+imsar_pkg::CRCP_POS][imsar_pkg::CRCP_BIT] : crcp_q[sel];
        body  = cnt_n - imsar_pkg::CPDU_OCT16;
        good  = nhold[15:0] == body && bas == body
                && nhold[23:16] == tag
                && (!CRC32_EN || !crcp || c == imsar_pkg::CRC32_RES);
        for (int i = 0; i < NSLOT; i++) begin
            exp_c[i] = act_q[i] && tmr_q[i] == '0 && !((start || cont) && sel == SW'(i));
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            act_q  <= '0;
            crcp_q <= '0;
            for (int i = 0; i < NSLOT; i++) begin
                svci_q[i] <= 20'h00000;
                smid_q[i] <= 10'h000;
                ssn_q[i]  <= 4'h0;
                tmr_q[i]  <= '0;
                cnt_q[i]  <= 16'h0000;
                bas_q[i]  <= 16'h0000;
                tag_q[i]  <= 8'h00;
                c32_q[i]  <= 32'h00000000;
                hold_q[i] <= 32'h00000000;
            end
        end else if (CE_I) begin
            for (int i = 0; i < NSLOT; i++) begin
                if (exp_c[i]) act_q[i] <= 1'b0;
                else if (act_q[i]) tmr_q[i] <= tmr_q[i] - 1'b1;
                if ((start || cont) && sel == SW'(i)) begin
                    act_q[i]  <= !fin;
                    svci_q[i] <= rvci_q;
                    smid_q[i] <= mid;
                    ssn_q[i]  <= sn;
                    cnt_q[i]  <= cnt_n;
                    bas_q[i]  <= bas;
                    tag_q[i]  <= tag;
                    crcp_q[i] <= crcp;
                    c32_q[i]  <= c;
                    hold_q[i] <= nhold;
                    if (start) tmr_q[i] <= RX_TIMEOUT_I;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RX_SU_O       <= '0;
            RX_SU_VALID_O <= 1'b0;
            RX_SU_FIRST_O <= 1'b0;
            RX_SU_LEN_O   <= 6'h00;
            RX_SU_SLOT_O  <= '0;
            RX_END_O      <= 1'b0;
            RX_GOOD_O     <= 1'b0;
            RX_END_SLOT_O <= '0;
            RX_EXPIRE_O   <= '0;
        end else if (CE_I) begin
            for (int k = 0; k < imsar_pkg::SU_OCT; k++) RX_SU_O[351-8*k -: 8] <= pl_q[imsar_pkg::HDR_OCT+k];
            RX_SU_VALID_O <= start || single || cont;
            RX_SU_FIRST_O <= start || single;
            RX_SU_LEN_O   <= ulen;
            RX_SU_SLOT_O  <= sel;
            RX_END_O      <= fin;
            RX_GOOD_O     <= fin && good;
            RX_END_SLOT_O <= sel;
            RX_EXPIRE_O   <= exp_c;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);

    chk_ssm_mid_zero: assert property (
        TX_DMPDU_VALID_O && TX_DMPDU_FIRST_O && TX_DMPDU_O[31:30] == imsar_pkg::ST_SSM |-> TX_DMPDU_O[25:16] == 10'h000)
        else $error("single unit sent with nonzero identifier");
    chk_full_unit_len: assert property (
        TX_DMPDU_VALID_O && txl_q && (ust_q == imsar_pkg::ST_BOM || ust_q == imsar_pkg::ST_COM)
        |-> TX_DMPDU_O[15:10] == imsar_pkg::SU_OCT6)
        else $error("begin or middle unit length not 44");
    chk_end_unit_len: assert property (
        TX_DMPDU_VALID_O && txl_q && ust_q == imsar_pkg::ST_EOM
        |-> TX_DMPDU_O[11:10] == 2'h0 && TX_DMPDU_O[15:10] >= imsar_pkg::EOM_MIN6
            && TX_DMPDU_O[15:10] <= imsar_pkg::SU_OCT6)
        else $error("end unit length out of range");
    chk_ssm_unit_len: assert property (
        TX_DMPDU_VALID_O && txl_q && ust_q == imsar_pkg::ST_SSM
        |-> TX_DMPDU_O[15:10] >= imsar_pkg::SSM_MIN6 && TX_DMPDU_O[15:10] <= imsar_pkg::SU_OCT6)
        else $error("single unit length out of range");
    chk_seq_step: assert property (
        $rose(TX_DMPDU_FIRST_O) && (TX_DMPDU_O[31:30] == imsar_pkg::ST_COM || TX_DMPDU_O[31:30] == imsar_pkg::ST_EOM)
        |-> TX_DMPDU_O[29:26] == prev_hdr_q[13:10] + 4'h1)
        else $error("sequence number did not advance by one");
    chk_mid_repeat: assert property (
        $rose(TX_DMPDU_FIRST_O) && (TX_DMPDU_O[31:30] == imsar_pkg::ST_COM || TX_DMPDU_O[31:30] == imsar_pkg::ST_EOM)
        |-> TX_DMPDU_O[25:16] == prev_hdr_q[9:0])
        else $error("continuation identifier differs from begin unit");
    chk_copy_crc_ok: assert property (
        RX_SU_VALID_O |-> rok_q)
        else $error("unit copied after payload crc failure");
    chk_end_frees: assert property (
        RX_END_O && !RX_SU_FIRST_O |-> !act_q[RX_END_SLOT_O])
        else $error("identifier still recorded after completion");
    chk_expire_frees: assert property (
        (|RX_EXPIRE_O) |-> (act_q & RX_EXPIRE_O) == '0)
        else $error("timed out slot still active");
endmodule

// *** verification/impdu_segmentation_reassembly_test.sv ***
`timescale 1ns/1ps
module impdu_segmentation_reassembly_test;
    localparam logic [63:0] ADDR = 64'h0123456789abcdef;
    logic         clk, rst_n, start, valid, flip, rdy, rxv, rxf, seen, expd;
    logic         busy, trdy, dv, df, su_v, su_f, end_o, good;
    logic [15:0]  len;
    logic [9:0]   mid;
    logic [31:0]  data, d_o, rxd;
    logic [351:0] su;
    logic [5:0]   su_len;
    logic [7:0]   tag;
    logic [19:0]  vci;
    logic [23:0]  tmo;
    logic [3:0]   exp_o;
    logic [31:0]  q[$];
    int           mismatches, checks_done, mode;
    imsar_top dut (.MCLK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .TX_START_I(start), .TX_LEN_I(len),
        .TX_MID_I(mid), .TX_BUSY_O(busy), .TX_DATA_I(data), .TX_VALID_I(valid), .TX_READY_O(trdy),
        .TX_DMPDU_O(d_o), .TX_DMPDU_VALID_O(dv), .TX_DMPDU_FIRST_O(df), .TX_DMPDU_READY_I(rdy),
        .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_FIRST_I(rxf), .RX_VCI_I(vci), .RX_PROG_VCI_I(20'h00123),
        .RX_ADDR_I(ADDR), .RX_TIMEOUT_I(tmo), .RX_SU_O(su), .RX_SU_VALID_O(su_v), .RX_SU_FIRST_O(su_f),
        .RX_SU_LEN_O(su_len), .RX_SU_SLOT_O(), .RX_END_O(end_o), .RX_GOOD_O(good), .RX_END_SLOT_O(),
        .RX_EXPIRE_O(exp_o));
    imsar_bus_model bus (.clk_i(clk), .tx_i(d_o), .tx_valid_i(dv), .tx_first_i(df), .flip_i(flip),
        .ready_o(rdy), .rx_o(rxd), .rx_valid_o(rxv), .rx_first_o(rxf));
    always @(posedge clk) if (dv && rdy) q.push_back(d_o);
    always @(negedge clk) if (|exp_o) expd = 1'b1;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] wd(input int i, input logic [15:0] n);
        if (i == n / 4 - 1 && mode == 2) return {16'h0000, n - 16'h0004};
        if (i == 0 || i == n / 4 - 1) return {16'h0000, n - 16'h0008};
        if (i == 1) return ADDR[63:32];
        if (i == 2) return ADDR[31:0];
        if (i == 5) return (mode == 1) ? 32'h00080000 : 32'h00000000;
        return 32'ha5a50000 + 32'(i);
    endfunction
    // send one message, then wait for the looped completion
    task automatic send(input logic [15:0] n, input logic [9:0] m);
        q = {};
        seen = 1'b0;
        len = n;
        mid = m;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        valid = 1'b1;
        for (int i = 0; i < n / 4; i++) begin
            data = wd(i, n);
            // ready is settled just after the falling edge
            #1;
            while (trdy !== 1'b1) begin
                @(negedge clk);
                #1;
            end
            @(negedge clk);
        end
        valid = 1'b0;
        repeat (80) begin
            @(negedge clk);
            if (end_o === 1'b1) break;
        end
        seen = end_o;
    endtask
    task automatic t_crc;
        flip = 1'b1;
        send(16'd28, 10'h000);
        chk(seen, 1'b0);
        flip = 1'b0;
    endtask
    task automatic t_ssm;
        send(16'd28, 10'h155);
        tag = q[0][7:0];
        chk({seen, good, su_f, su_v}, 4'hf);
        chk(su_len, 6'h1c);
        chk(su[319:256], ADDR);
        chk(q[0][31:30], imsar_pkg::ST_SSM);
        chk(q[0][25:16], 10'h000);
        chk(q[11][15:10], 6'h1c);
    endtask
    task automatic t_multi;
        send(16'd60, 10'h2a5);
        chk({seen, good}, 2'h3);
        chk(su_len, 6'h10);
        chk(q[0][31:30], imsar_pkg::ST_BOM);
        chk(q[0][25:16], 10'h2a5);
        chk(q[0][7:0], tag + 8'h01);
        chk(q[1], {16'h0034, ADDR[63:48]});
        chk(q[11][15:10], 6'h2c);
        chk(q[12][31:30], imsar_pkg::ST_EOM);
        chk(q[12][29:26], 4'(q[0][29:26] + 4'h1));
        chk(q[12][25:16], 10'h2a5);
        chk(q[23][15:10], 6'h10);
        chk(expd, 1'b0);
    endtask
    task automatic t_vci;
        vci = 20'h00456;
        send(16'd28, 10'h000);
        chk(seen, 1'b0);
        vci = 20'h00123;
        send(16'd28, 10'h000);
        chk({seen, good}, 2'h3);
        vci = 20'hfffff;
    endtask
    task automatic t_bad;
        mode = 1;
        send(16'd60, 10'h0c3);
        chk({seen, good}, 2'h2);
        mode = 2;
        send(16'd28, 10'h000);
        chk({seen, good}, 2'h2);
        mode = 0;
    endtask
    task automatic t_tmo;
        tmo = 24'h000004;
        expd = 1'b0;
        send(16'd60, 10'h0c3);
        chk({seen, expd}, 2'h1);
        tmo = 24'h000032;
    endtask
    task automatic results;
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        {rst_n, start, valid, flip, expd, len, mid, data} = '0;
        vci = 20'hfffff;
        tmo = 24'h000032;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_crc();
        t_ssm();
        t_multi();
        t_vci();
        t_bad();
        t_tmo();
        results();
    end
endmodule

// *** verification/imsar_bus_model.sv ***
`timescale 1ns/1ps
module imsar_bus_model (
    input  wire logic        clk_i,      // clock
    input  wire logic [31:0] tx_i,       // sent word
    input  wire logic        tx_valid_i, // sent word valid
    input  wire logic        tx_first_i, // sent first word
    input  wire logic        flip_i,     // corrupt looped words
    output logic             ready_o,    // word taken
    output logic [31:0]      rx_o,       // looped word
    output logic             rx_valid_o, // looped valid
    output logic             rx_first_o  // looped first
);
    logic [1:0]  cnt;
    logic        acc;
    logic        fst;
    logic [31:0] w;
    initial begin
        cnt = 2'h0;
        ready_o = 1'b0;
        rx_o = 32'h0;
        rx_valid_o = 1'b0;
        rx_first_o = 1'b0;
    end
    always @(posedge clk_i) begin
        acc <= tx_valid_i & ready_o;
        fst <= tx_first_i;
        w <= tx_i;
    end
    // stall one cycle in four; idle bus shows inverted data
    always @(negedge clk_i) begin
        cnt <= cnt + 2'h1;
        ready_o <= (cnt != 2'h3);
        rx_valid_o <= acc;
        rx_first_o <= acc & fst;
        rx_o <= acc ? (w ^ {31'h0, flip_i}) : ~rx_o;
    end
endmodule
